// >>> slbs_params.svh
`ifndef SLBS_PARAMS_SVH
`define SLBS_PARAMS_SVH
`define SLBS_CLK_HZ 100000000
`define SLBS_TICK_MS 10
`define SLBS_CAN_FAST_MS 50
`define SLBS_CAN_SLOW_MS 200
`define SLBS_CAN_OFF_MS 800
`define SLBS_HZ2_HALF_MS 250
`define SLBS_FAST_HALF_MS 50
`define SLBS_CODE_HALF_MS 500
`define SLBS_PAUSE_MS 1000
`define SLBS_FLICKER_PULSES 10
`define SLBS_GREEN_PAIR 2
`endif

// >>> slbs_pkg.sv
package slbs_pkg;
	typedef enum logic [1:0] {
		SLBS_DARK = 2'h0,
		SLBS_RED = 2'h1,
		SLBS_GREEN = 2'h2,
		SLBS_ORANGE = 2'h3
	} slbs_colour_t;
	typedef enum logic [2:0] {
		SLBS_CAN_UNCFG = 3'h0,
		SLBS_CAN_CFG_BUSY = 3'h1,
		SLBS_CAN_CFG_BAD = 3'h2,
		SLBS_CAN_STOP = 3'h3,
		SLBS_CAN_PREOP = 3'h4,
		SLBS_CAN_OPER = 3'h5,
		SLBS_CAN_BUSOFF = 3'h6
	} slbs_can_state_t;
	typedef enum logic [1:0] {
		SLBS_FB_OFF = 2'h0,
		SLBS_FB_SEARCH = 2'h1,
		SLBS_FB_NODATA = 2'h2,
		SLBS_FB_OK = 2'h3
	} slbs_fb_state_t;
endpackage

// >>> slbs_tick.sv
`timescale 1ns/10ps
`include "slbs_params.svh"
// free-running timebase, one tick every TICK_MS milliseconds
module slbs_tick #(
	parameter int CLK_HZ = `SLBS_CLK_HZ,
	parameter int TICK_MS = `SLBS_TICK_MS
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic clk_en,
	// timebase pulse
	output logic tick
);
	localparam int DIV = CLK_HZ / 1000 * TICK_MS;
	logic [31:0] cnt_q;
	logic wrap;
	assign wrap = (cnt_q == 32'(DIV - 1));
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			cnt_q <= 32'h0;
		else if (clk_en)
			cnt_q <= wrap ? 32'h0 : cnt_q + 32'h1;
	end
	assign tick = clk_en && wrap;
endmodule

// >>> slbs_blink_code.sv
`timescale 1ns/10ps
`include "slbs_params.svh"
// three-group cyclic blink code: flicker, error code, error argument
module slbs_blink_code #(
	parameter int TICK_MS = `SLBS_TICK_MS,
	parameter int CW = 8
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic tick,
	// request
	input wire logic run,
	input wire logic [CW-1:0] err_code,
	input wire logic [CW-1:0] err_arg,
	// lamp
	output logic lamp
);
	localparam int FAST = `SLBS_FAST_HALF_MS / TICK_MS;
	localparam int SLOW = `SLBS_CODE_HALF_MS / TICK_MS;
	localparam int PAUSE = `SLBS_PAUSE_MS / TICK_MS;
	typedef enum logic [4:0] {
		SLBS_BC_IDLE = 5'h01,
		SLBS_BC_FLICK = 5'h02,
		SLBS_BC_CODE = 5'h04,
		SLBS_BC_ARG = 5'h08,
		SLBS_BC_PAUSE = 5'h10
	} slbs_bc_state_t;
	slbs_bc_state_t st_q;
	slbs_bc_state_t after_q;
	logic [15:0] tmr_q;
	logic [CW-1:0] left_q;
	logic [CW-1:0] code_q;
	logic [CW-1:0] arg_q;
	logic ph_q;
	logic half_done;
	logic last_pulse;
	assign half_done = tick && (tmr_q == 16'h0);
	assign last_pulse = ph_q && (left_q <= CW'(1));
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			st_q <= SLBS_BC_IDLE;
			after_q <= SLBS_BC_IDLE;
			tmr_q <= 16'h0;
			left_q <= '0;
			code_q <= '0;
			arg_q <= '0;
			ph_q <= 1'b0;
			lamp <= 1'b0;
		end
		else if (clk_en)
		begin
			case (st_q)
				SLBS_BC_IDLE:
				begin
					lamp <= 1'b0;
					if (run)
					begin
						// latch once per cycle so a change waits for the next one
						code_q <= err_code;
						arg_q <= err_arg;
						left_q <= CW'(`SLBS_FLICKER_PULSES);
						tmr_q <= 16'(FAST - 1);
						ph_q <= 1'b1;
						lamp <= 1'b1;
						st_q <= SLBS_BC_FLICK;
					end
				end
				SLBS_BC_FLICK, SLBS_BC_CODE, SLBS_BC_ARG:
				begin
					if (tick)
						tmr_q <= tmr_q - 16'h1;
					if (half_done)
					begin
						tmr_q <= (st_q == SLBS_BC_FLICK) ? 16'(FAST - 1) : 16'(SLOW - 1);
						if (last_pulse || left_q == '0)
						begin
							lamp <= 1'b0;
							tmr_q <= 16'(PAUSE - 1);
							st_q <= SLBS_BC_PAUSE;
							case (st_q)
								SLBS_BC_FLICK: after_q <= SLBS_BC_CODE;
								SLBS_BC_CODE: after_q <= SLBS_BC_ARG;
								default: after_q <= SLBS_BC_IDLE;
							endcase
						end
						else
						begin
							if (ph_q)
								left_q <= left_q - CW'(1);
							ph_q <= !ph_q;
							lamp <= !ph_q;
						end
					end
				end
				SLBS_BC_PAUSE:
				begin
					if (tick)
						tmr_q <= tmr_q - 16'h1;
					if (half_done)
					begin
						st_q <= after_q;
						tmr_q <= 16'(SLOW - 1);
						ph_q <= 1'b1;
						if (after_q == SLBS_BC_CODE)
						begin
							left_q <= code_q;
							lamp <= (code_q != '0);
						end
						else if (after_q == SLBS_BC_ARG)
						begin
							left_q <= arg_q;
							lamp <= (arg_q != '0);
						end
						else
							lamp <= 1'b0;
					end
				end
				default:
					st_q <= SLBS_BC_IDLE;
			endcase
		end
	end
endmodule

// >>> slbs_led_seq.sv
`timescale 1ns/10ps
`include "slbs_params.svh"
// Function
// - I/O indicator steady green during normal bus data cycles.
// - I/O indicator flashes orange rapidly during bus initialisation.
// - I/O indicator steady red on hardware fault.
// - I/O indicator flashes red at 2 Hz on recoverable error.
// - I/O indicator shows red blink-code sequence on bus error.
// - I/O indicator dark when library not loaded or not called.
// - CAN indicator off while unconfigured.
// - CAN indicator alternates red/green 50 ms each while configuring.
// - CAN indicator alternates red/green 200 ms each on invalid configuration.
// - CAN Stop: green 200 ms then off 800 ms, repeating.
// - CAN Preoperational: green 200 ms then off 200 ms, repeating.
// - CAN Operational without error: steady green.
// - CAN bus-off: steady red.
// - Preoperational error: N red flashes then two green flashes, repeating.
// - Operational error: N red flashes then green 800 ms, repeating.
// - fieldbus indicator steady red while no communication, finding baud rate.
// - fieldbus red flashing without process data; steady green when error-free.
// - fieldbus indicator off when interface deactivated.
// - diagnosis shown cyclically as flicker, code and argument groups.
// - after flicker, one second pause, then pulses equal to error code.
// - after another pause, pulses equal to error argument.
// - flicker at about 10 Hz followed by one second pause.
// - code and argument pulses at about 1 Hz.
// - with error pending, sequence restarts with flicker and repeats.
module slbs_led_seq #(
	parameter int CLK_HZ = `SLBS_CLK_HZ,
	parameter int TICK_MS = `SLBS_TICK_MS,
	parameter int CW = 8
) (
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic clk_en,
	// local bus indicator conditions, priority high to low as listed
	input wire logic io_hw_fault,
	input wire logic io_bus_err,
	input wire logic [CW-1:0] io_err_code,
	input wire logic [CW-1:0] io_err_arg,
	input wire logic io_recov_err,
	input wire logic io_init,
	input wire logic io_running,
	// can indicator conditions
	input wire slbs_pkg::slbs_can_state_t can_state,
	input wire logic [1:0] can_err_n,
	// fieldbus indicator conditions
	input wire slbs_pkg::slbs_fb_state_t fb_state,
	// indicator drive
	output logic io_led_red,
	output logic io_led_green,
	output logic can_led_red,
	output logic can_led_green,
	output logic fieldbus_fault_indicator_red,
	output logic fieldbus_fault_indicator_green
);
	localparam int T_FAST = `SLBS_FAST_HALF_MS / TICK_MS;
	localparam int T_HZ2 = `SLBS_HZ2_HALF_MS / TICK_MS;
	localparam int T_CF = `SLBS_CAN_FAST_MS / TICK_MS;
	localparam int T_CS = `SLBS_CAN_SLOW_MS / TICK_MS;
	localparam int T_CO = `SLBS_CAN_OFF_MS / TICK_MS;

	// ticks of one pattern half, never below one
	function automatic logic [15:0] half_ticks(input int t);
		half_ticks = (t < 1) ? 16'h1 : 16'(t);
	endfunction

	logic tick;
	logic bc_lamp;
	slbs_tick #(
		.CLK_HZ(CLK_HZ),
		.TICK_MS(TICK_MS)
	) slbs_tick_inst (
		.core_clk(core_clk),
		.nrst(nrst),
		.clk_en(clk_en),
		.tick(tick)
	);

	slbs_blink_code #(
		.TICK_MS(TICK_MS),
		.CW(CW)
	) slbs_blink_code_inst (
		.core_clk(core_clk),
		.nrst(nrst),
		.clk_en(clk_en),
		.tick(tick),
		.run(io_bus_err),
		.err_code(io_err_code),
		.err_arg(io_err_arg),
		.lamp(bc_lamp)
	);

	// free-running square waves for the local and fieldbus indicators
	logic [15:0] fast_q;
	logic [15:0] hz2_q;
	logic fast_ph_q;
	logic hz2_ph_q;
	logic fast_wrap;
	logic hz2_wrap;
	assign fast_wrap = (fast_q >= half_ticks(T_FAST) - 16'h1);
	assign hz2_wrap = (hz2_q >= half_ticks(T_HZ2) - 16'h1);
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			fast_q <= 16'h0;
			hz2_q <= 16'h0;
			fast_ph_q <= 1'b0;
			hz2_ph_q <= 1'b0;
		end
		else if (clk_en && tick)
		begin
			fast_q <= fast_wrap ? 16'h0 : fast_q + 16'h1;
			hz2_q <= hz2_wrap ? 16'h0 : hz2_q + 16'h1;
			if (fast_wrap)
				fast_ph_q <= !fast_ph_q;
			if (hz2_wrap)
				hz2_ph_q <= !hz2_ph_q;
		end
	end

	// local bus indicator
	slbs_pkg::slbs_colour_t io_col;
	assign io_col = io_hw_fault ? slbs_pkg::SLBS_RED :
		io_bus_err ? (bc_lamp ? slbs_pkg::SLBS_RED : slbs_pkg::SLBS_DARK) :
		io_recov_err ? (hz2_ph_q ? slbs_pkg::SLBS_RED : slbs_pkg::SLBS_DARK) :
		io_init ? (fast_ph_q ? slbs_pkg::SLBS_ORANGE : slbs_pkg::SLBS_DARK) :
		io_running ? slbs_pkg::SLBS_GREEN :
		slbs_pkg::SLBS_DARK;

	// can indicator: phase sequencer, each phase a colour and a duration
	typedef enum logic [3:0] {
		SLBS_CP_A = 4'h1,
		SLBS_CP_B = 4'h2,
		SLBS_CP_RED = 4'h4,
		SLBS_CP_GRN = 4'h8
	} slbs_cp_t;
	slbs_cp_t cp_q;
	slbs_pkg::slbs_can_state_t can_prev_q;
	logic [1:0] err_prev_q;
	logic [15:0] ct_q;
	logic [2:0] cn_q;
	logic [2:0] flash_q;
	logic can_ph_q;
	logic can_restart;
	logic can_err;
	logic ct_done;
	logic can_oper;
	logic can_preop;
	logic can_cfg;
	logic can_beacon;
	logic can_busoff;
	assign can_oper = (can_state == slbs_pkg::SLBS_CAN_OPER);
	assign can_preop = (can_state == slbs_pkg::SLBS_CAN_PREOP);
	assign can_cfg = (can_state == slbs_pkg::SLBS_CAN_CFG_BUSY) ||
		(can_state == slbs_pkg::SLBS_CAN_CFG_BAD);
	assign can_beacon = (can_state == slbs_pkg::SLBS_CAN_STOP) || can_preop;
	assign can_busoff = (can_state == slbs_pkg::SLBS_CAN_BUSOFF);
	assign can_err = (can_err_n != 2'h0) && (can_oper || can_preop);
	assign can_restart = (can_state != can_prev_q) || (can_err_n != err_prev_q);
	assign ct_done = tick && (ct_q == 16'h0);

	// reload count of the phase being entered, one tick less than its duration
	function automatic logic [15:0] can_len(input slbs_pkg::slbs_can_state_t s,
		input slbs_cp_t p);
		case (s)
			slbs_pkg::SLBS_CAN_CFG_BUSY: can_len = half_ticks(T_CF) - 16'h1;
			slbs_pkg::SLBS_CAN_STOP: can_len = (p == SLBS_CP_B) ?
				half_ticks(T_CO) - 16'h1 : half_ticks(T_CS) - 16'h1;
			default: can_len = half_ticks(T_CS) - 16'h1;
		endcase
	endfunction

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			cp_q <= SLBS_CP_A;
			can_prev_q <= slbs_pkg::SLBS_CAN_UNCFG;
			err_prev_q <= 2'h0;
			ct_q <= 16'h0;
			cn_q <= 3'h0;
			flash_q <= 3'h0;
			can_ph_q <= 1'b0;
		end
		else if (clk_en)
		begin
			can_prev_q <= can_state;
			err_prev_q <= can_err_n;
			if (can_restart)
			begin
				// only an error pattern opens in SLBS_CP_RED; plain preop needs its green phase
				cp_q <= can_err ? SLBS_CP_RED : SLBS_CP_A;
				ct_q <= can_len(can_state, SLBS_CP_A);
				cn_q <= {1'b0, can_err_n};
				flash_q <= 3'h0;
				can_ph_q <= 1'b1;
			end
			else
			begin
				if (tick)
					ct_q <= ct_q - 16'h1;
				if (ct_done)
				begin
					ct_q <= can_len(can_state, cp_q);
					case (cp_q)
						SLBS_CP_A:
						begin
							cp_q <= SLBS_CP_B;
							ct_q <= can_len(can_state, SLBS_CP_B);
						end
						SLBS_CP_B:
						begin
							cp_q <= SLBS_CP_A;
							ct_q <= can_len(can_state, SLBS_CP_A);
						end
						SLBS_CP_RED:
						begin
							// red flash then dark gap; count completed flashes
							can_ph_q <= !can_ph_q;
							if (!can_ph_q && (flash_q + 3'h1 >= cn_q))
							begin
								cp_q <= SLBS_CP_GRN;
								flash_q <= 3'h0;
								can_ph_q <= 1'b1;
								if (can_state == slbs_pkg::SLBS_CAN_OPER)
									ct_q <= half_ticks(T_CO) - 16'h1;
							end
							else if (!can_ph_q)
								flash_q <= flash_q + 3'h1;
						end
						SLBS_CP_GRN:
						begin
							can_ph_q <= !can_ph_q;
							if (can_state == slbs_pkg::SLBS_CAN_OPER ||
								(!can_ph_q && flash_q + 3'h1 >= 3'(`SLBS_GREEN_PAIR)))
							begin
								cp_q <= SLBS_CP_RED;
								flash_q <= 3'h0;
								can_ph_q <= 1'b1;
							end
							else if (!can_ph_q)
								flash_q <= flash_q + 3'h1;
						end
						default:
							cp_q <= SLBS_CP_A;
					endcase
				end
			end
		end
	end

	slbs_pkg::slbs_colour_t can_col;
	assign can_col = can_busoff ? slbs_pkg::SLBS_RED :
		can_err ? ((cp_q == SLBS_CP_RED) ?
			(can_ph_q ? slbs_pkg::SLBS_RED : slbs_pkg::SLBS_DARK) :
			(can_ph_q ? slbs_pkg::SLBS_GREEN : slbs_pkg::SLBS_DARK)) :
		can_oper ? slbs_pkg::SLBS_GREEN :
		can_cfg ?
			((cp_q == SLBS_CP_A) ? slbs_pkg::SLBS_RED : slbs_pkg::SLBS_GREEN) :
		can_beacon ?
			((cp_q == SLBS_CP_A) ? slbs_pkg::SLBS_GREEN : slbs_pkg::SLBS_DARK) :
		slbs_pkg::SLBS_DARK;

	// fieldbus fault indicator
	slbs_pkg::slbs_colour_t fb_col;
	logic fb_search;
	logic fb_nodata;
	logic fb_ok;
	assign fb_search = (fb_state == slbs_pkg::SLBS_FB_SEARCH);
	assign fb_nodata = (fb_state == slbs_pkg::SLBS_FB_NODATA);
	assign fb_ok = (fb_state == slbs_pkg::SLBS_FB_OK);
	// the no-data flash shares the 2 hz wave of the local indicator
	assign fb_col = fb_search ? slbs_pkg::SLBS_RED :
		fb_nodata ? (hz2_ph_q ? slbs_pkg::SLBS_RED : slbs_pkg::SLBS_DARK) :
		fb_ok ? slbs_pkg::SLBS_GREEN :
		slbs_pkg::SLBS_DARK;

	// registered lamp drive
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			io_led_red <= 1'b0;
			io_led_green <= 1'b0;
			can_led_red <= 1'b0;
			can_led_green <= 1'b0;
			fieldbus_fault_indicator_red <= 1'b0;
			fieldbus_fault_indicator_green <= 1'b0;
		end
		else if (clk_en)
		begin
			io_led_red <= io_col[0];
			io_led_green <= io_col[1];
			can_led_red <= can_col[0];
			can_led_green <= can_col[1];
			fieldbus_fault_indicator_red <= fb_col[0];
			fieldbus_fault_indicator_green <= fb_col[1];
		end
	end
endmodule

// >>> slbs_led_seq_checker.sv
`timescale 1ns/10ps
module slbs_led_seq_checker #(
	parameter int CLK_HZ = 100000000,
	parameter int TICK_MS = 10,
	parameter int CW = 8
) (
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic clk_en,
	// conditions
	input wire logic io_hw_fault,
	input wire logic io_bus_err,
	input wire logic io_recov_err,
	input wire logic io_init,
	input wire logic io_running,
	input wire slbs_pkg::slbs_can_state_t can_state,
	input wire logic [1:0] can_err_n,
	input wire slbs_pkg::slbs_fb_state_t fb_state,
	// indicators
	input wire logic io_led_red,
	input wire logic io_led_green,
	input wire logic can_led_red,
	input wire logic can_led_green,
	input wire logic fieldbus_fault_indicator_red,
	input wire logic fieldbus_fault_indicator_green
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	wire io_busy = io_hw_fault || io_bus_err || io_recov_err || io_init;
	wire io_run_only = io_running && !io_busy;
	wire io_dark = !io_running && !io_busy;
	wire can_busy = can_state == slbs_pkg::SLBS_CAN_CFG_BUSY;
	wire can_off = can_state == slbs_pkg::SLBS_CAN_BUSOFF;
	wire can_op = can_state == slbs_pkg::SLBS_CAN_OPER && can_err_n == 2'h0;
	wire can_unc = can_state == slbs_pkg::SLBS_CAN_UNCFG;
	wire fb_ok = fb_state == slbs_pkg::SLBS_FB_OK;
	property p_hw;
		(clk_en && io_hw_fault)[*2] |=> io_led_red && !io_led_green;
	endproperty
	a_hw: assert property (p_hw) else $error("io not red on fault");
	property p_run;
		(clk_en && io_run_only)[*2] |=> io_led_green && !io_led_red;
	endproperty
	a_run: assert property (p_run) else $error("io not green");
	property p_dark;
		(clk_en && io_dark)[*2] |=> !io_led_green && !io_led_red;
	endproperty
	a_dark: assert property (p_dark) else $error("io not dark");
	property p_berr;
		(clk_en && io_bus_err && !io_hw_fault)[*2] |=> !io_led_green;
	endproperty
	a_berr: assert property (p_berr) else $error("io green in blink code");
	property p_cunc;
		(clk_en && can_unc)[*2] |=> !can_led_red && !can_led_green;
	endproperty
	a_cunc: assert property (p_cunc) else $error("can lit unconfigured");
	property p_coff;
		(clk_en && can_off)[*2] |=> can_led_red && !can_led_green;
	endproperty
	a_coff: assert property (p_coff) else $error("can not red on bus off");
	property p_cop;
		(clk_en && can_op)[*2] |=> can_led_green && !can_led_red;
	endproperty
	a_cop: assert property (p_cop) else $error("can not green operational");
	property p_cbusy;
		(clk_en && can_busy)[*2] |=> can_led_red != can_led_green;
	endproperty
	a_cbusy: assert property (p_cbusy) else $error("can not alternating");
	property p_fbok;
		(clk_en && fb_ok)[*2] |=> fieldbus_fault_indicator_green && !fieldbus_fault_indicator_red;
	endproperty
	a_fbok: assert property (p_fbok) else $error("fieldbus not green");
	cover property (io_bus_err && $rose(io_led_red));
	cover property (can_busy && $rose(can_led_green));
	cover property (fb_state == slbs_pkg::SLBS_FB_NODATA && $rose(fieldbus_fault_indicator_red));
endmodule
bind slbs_led_seq slbs_led_seq_checker #(.CLK_HZ(CLK_HZ), .TICK_MS(TICK_MS), .CW(CW)) chk_inst (
	.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .io_hw_fault(io_hw_fault),
	.io_bus_err(io_bus_err), .io_recov_err(io_recov_err), .io_init(io_init),
	.io_running(io_running), .can_state(can_state), .can_err_n(can_err_n), .fb_state(fb_state),
	.io_led_red(io_led_red), .io_led_green(io_led_green), .can_led_red(can_led_red),
	.can_led_green(can_led_green), .fieldbus_fault_indicator_red(fieldbus_fault_indicator_red),
	.fieldbus_fault_indicator_green(fieldbus_fault_indicator_green)
);

// >>> slbs_panel.sv
`timescale 1ns/10ps
// bicolour lamp: counts how often each colour lights up
module slbs_panel (
	// clock
	input wire logic core_clk,
	// lamp drive
	input wire logic red,
	input wire logic green,
	// flash counts
	output logic [15:0] n_red,
	output logic [15:0] n_green
);
	logic red_q = 1'b0;
	logic green_q = 1'b0;
	logic [15:0] red_cnt = 16'h0000;
	logic [15:0] green_cnt = 16'h0000;
	assign n_red = red_cnt;
	assign n_green = green_cnt;
	always @(posedge core_clk)
	begin
		red_q <= red;
		green_q <= green;
		if (red === 1'b1 && red_q !== 1'b1)
			red_cnt <= red_cnt + 16'h0001;
		if (green === 1'b1 && green_q !== 1'b1)
			green_cnt <= green_cnt + 16'h0001;
	end
endmodule

// >>> slbs_led_seq_test.sv
`timescale 1ns/10ps
module slbs_led_seq_test;
	logic core_clk, nrst, clk_en, io_hw_fault, io_bus_err, io_recov_err, io_init, io_running;
	logic [7:0] io_err_code, io_err_arg;
	logic [1:0] can_err_n;
	slbs_pkg::slbs_can_state_t can_state;
	slbs_pkg::slbs_fb_state_t fb_state;
	logic io_r, io_g, can_r, can_g, fb_r, fb_g;
	wire [2:0][15:0] nr, ng;
	logic [2:0][15:0] dr, dg;
	int num_errors = 0;
	int n_checks = 0;
	// shortened timebase: one millisecond is one clock cycle
	slbs_led_seq #(.CLK_HZ(1000)) slbs_led_seq_inst (
		.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .io_hw_fault(io_hw_fault),
		.io_bus_err(io_bus_err), .io_err_code(io_err_code), .io_err_arg(io_err_arg),
		.io_recov_err(io_recov_err), .io_init(io_init), .io_running(io_running),
		.can_state(can_state), .can_err_n(can_err_n), .fb_state(fb_state),
		.io_led_red(io_r), .io_led_green(io_g), .can_led_red(can_r), .can_led_green(can_g),
		.fieldbus_fault_indicator_red(fb_r), .fieldbus_fault_indicator_green(fb_g)
	);
	slbs_panel p_io (.core_clk(core_clk), .red(io_r), .green(io_g), .n_red(nr[0]), .n_green(ng[0]));
	slbs_panel p_cn (.core_clk(core_clk), .red(can_r), .green(can_g), .n_red(nr[1]), .n_green(ng[1]));
	slbs_panel p_fb (.core_clk(core_clk), .red(fb_r), .green(fb_g), .n_red(nr[2]), .n_green(ng[2]));
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task tally_and_finish;
		if (num_errors == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task step(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task chk(input logic [15:0] got, input int lo, input int hi);
		n_checks++;
		if ($isunknown(got) || got < lo || got > hi)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask
	task win(input int n);
		logic [2:0][15:0] r0, g0;
		r0 = nr;
		g0 = ng;
		step(n);
		for (int i = 0; i < 3; i++)
		begin
			dr[i] = nr[i] - r0[i];
			dg[i] = ng[i] - g0[i];
		end
	endtask
	task cpat(input slbs_pkg::slbs_can_state_t s, input logic [1:0] e, input int n,
		input int rl, input int rh, input int gl, input int gh);
		@(posedge core_clk);
		can_state <= s;
		can_err_n <= e;
		win(n);
		chk(dr[1], rl, rh);
		chk(dg[1], gl, gh);
	endtask
	task t_io;
		@(posedge core_clk);
		io_running <= 1'b1;
		step(3);
		chk({io_r, io_g}, 1, 1);
		io_hw_fault <= 1'b1;
		step(3);
		chk({io_r, io_g}, 2, 2);
		io_hw_fault <= 1'b0;
		io_running <= 1'b0;
		io_init <= 1'b1;
		win(1000);
		chk(dr[0], 9, 11);
		chk(dg[0], 9, 11);
		clk_en <= 1'b0;
		// let a lamp change from the last enabled edge reach the counters first
		step(2);
		win(300);
		chk(dr[0] + dg[0], 0, 0);
		clk_en <= 1'b1;
		io_init <= 1'b0;
		io_recov_err <= 1'b1;
		win(2000);
		chk(dr[0], 3, 5);
		chk(dg[0], 0, 0);
		io_recov_err <= 1'b0;
		step(3);
		chk({io_r, io_g}, 0, 0);
	endtask
	task t_blink;
		logic [15:0] r0;
		int i;
		io_err_code <= 8'h02;
		io_err_arg <= 8'h03;
		io_bus_err <= 1'b1;
		r0 = nr[0];
		i = 0;
		while (nr[0] === r0 && i < 3000)
		begin
			step(1);
			i++;
		end
		if (i == 3000)
		begin
			num_errors++;
			tally_and_finish();
		end
		win(950);
		chk(dr[0], 9, 9);
		step(250);
		io_err_code <= 8'h04;
		step(300);
		win(2300);
		chk(dr[0], 2, 2);
		win(4000);
		chk(dr[0], 3, 3);
		step(100);
		win(200);
		chk(dr[0], 1, 2);
		step(1400);
		win(4300);
		chk(dr[0], 4, 4);
		io_bus_err <= 1'b0;
	endtask
	task t_can;
		cpat(slbs_pkg::SLBS_CAN_UNCFG, 2'h0, 300, 0, 0, 0, 0);
		cpat(slbs_pkg::SLBS_CAN_CFG_BUSY, 2'h0, 2000, 19, 21, 19, 21);
		cpat(slbs_pkg::SLBS_CAN_CFG_BAD, 2'h0, 2000, 4, 6, 4, 6);
		cpat(slbs_pkg::SLBS_CAN_STOP, 2'h0, 2000, 0, 0, 1, 3);
		cpat(slbs_pkg::SLBS_CAN_PREOP, 2'h0, 2000, 0, 0, 4, 6);
		cpat(slbs_pkg::SLBS_CAN_PREOP, 2'h1, 2400, 1, 3, 3, 5);
		cpat(slbs_pkg::SLBS_CAN_PREOP, 2'h2, 3200, 3, 5, 3, 5);
		cpat(slbs_pkg::SLBS_CAN_OPER, 2'h3, 4000, 5, 7, 1, 3);
		cpat(slbs_pkg::SLBS_CAN_OPER, 2'h0, 300, 0, 0, 0, 1);
		chk({can_r, can_g}, 1, 1);
		cpat(slbs_pkg::SLBS_CAN_BUSOFF, 2'h0, 300, 0, 1, 0, 0);
		chk({can_r, can_g}, 2, 2);
	endtask
	task t_fb;
		fb_state <= slbs_pkg::SLBS_FB_SEARCH;
		step(3);
		chk({fb_r, fb_g}, 2, 2);
		fb_state <= slbs_pkg::SLBS_FB_NODATA;
		win(2000);
		chk(dr[2], 3, 5);
		fb_state <= slbs_pkg::SLBS_FB_OK;
		step(3);
		chk({fb_r, fb_g}, 1, 1);
		fb_state <= slbs_pkg::SLBS_FB_OFF;
		step(3);
		chk({fb_r, fb_g}, 0, 0);
	endtask
	initial
	begin
		{nrst, io_hw_fault, io_bus_err, io_recov_err, io_init, io_running} <= 6'h00;
		clk_en <= 1'b1;
		io_err_code <= 8'h00;
		io_err_arg <= 8'h00;
		can_err_n <= 2'h0;
		can_state <= slbs_pkg::SLBS_CAN_UNCFG;
		fb_state <= slbs_pkg::SLBS_FB_OFF;
		step(20);
		nrst <= 1'b1;
		step(2);
		t_io();
		t_blink();
		t_can();
		t_fb();
		tally_and_finish();
	end
endmodule
